// File: core/pps_pkg.sv
// Constants for the downstream port power / over-current select register bank.
// Assumes an AXI4-Lite master with 32-bit data; every register uses the low byte of its word.
package pps_pkg;

    localparam int          ADDR_W     = 20;
    localparam int          IDX_W      = 18;

    // Register indexes; the byte address is four times the index
    localparam logic [17:0] IDX_PWR3   = 18'h03c08;
    localparam logic [17:0] IDX_OVC1   = 18'h03c20;
    localparam logic [17:0] IDX_OVC2   = 18'h03c24;
    localparam logic [17:0] IDX_OVC3   = 18'h03c28;
    localparam logic [17:0] IDX_CHG    = 18'h05246;
    localparam logic [17:0] IDX_IRQ_ST = 18'h05248;
    localparam logic [17:0] IDX_IRQ_CL = 18'h05249;
    localparam logic [17:0] IDX_IRQ_EN = 18'h0524a;

    // Field positions in the power select byte
    localparam int          SHARED_BIT = 7;
    localparam int          RSVD_BIT   = 6;
    localparam int          DIS_BIT    = 5;
    localparam int          NONREM_BIT = 4;

    // Interrupt status layout: [2:0] charging host seen, [5:3] over-current rise
    localparam int          IRQ_CHG_LSB = 0;
    localparam int          IRQ_OC_LSB  = 3;

    // Reset values; PWR3_RST and OVC_RST are held only until the configuration load one edge after reset
    localparam logic [7:0]  PWR3_RST   = 8'h00;
    localparam logic [3:0]  OVC_RST    = 4'h0;
    localparam logic [2:0]  CHG_RST    = 3'h0;
    localparam logic [5:0]  IRQ_RST    = 6'h00;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [3:0]
    {
        PWR_OFF    = 4'h0,
        PWR_USB2   = 4'h1,
        PWR_USB3   = 4'h2,
        PWR_EITHER = 4'h3,
        PWR_GPIO   = 4'h4
    } pps_pwr_e;

    typedef enum logic [3:0]
    {
        OC_DISABLED = 4'h0,
        OC_PIN      = 4'h1,
        OC_GPIO     = 4'h2,
        OC_FORCE    = 4'hf
    } pps_oc_e;

endpackage

// File: core/pps_regs.sv
// Port power source and over-current source select registers with an AXI4-Lite slave.
// Assumes configuration values, hub power states, handshake pulses and the enumerated level
// come from logic on clk; sense and GPIO pins are asynchronous and are synchronised here.
//
// Behaviour
// - Port 3 shared flag set means power and over-current sense share one pin.
// - Port 3 disable bit forces port off and reports it unavailable.
// - Port 3 non-removable bit is reported as a permanently attached device.
// - Power code 0 off, 1 follows USB2 power, 2 follows USB3 power.
// - Power code 3 follows USB2 or USB3, 4 follows GPIO, rest reserved.
// - Over-current code 0 disables port, 1 dedicated pin, 2 GPIO.
// - Over-current code f forces indication on; other codes reserved.
// - Charging bits 2:0 record a charging host handshake seen before enumeration.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module pps_regs
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [19:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [19:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  cfg_port3_power_select,
    input  wire logic [3:0]  cfg_port1_overcurrent_code,
    input  wire logic [3:0]  cfg_port2_overcurrent_code,
    input  wire logic [3:0]  cfg_port3_overcurrent_code,
    input  wire logic        usb2_port_power_on,
    input  wire logic        usb3_port_power_on,
    input  wire logic        hub_enumerated,
    input  wire logic [2:0]  charging_host_port_detect,
    input  wire logic        power_gpio_pin,
    input  wire logic [2:0]  overcurrent_sense_pin,
    input  wire logic [2:0]  overcurrent_gpio_pin,
    input  wire logic        port3_power_in,
    output logic             port3_power_out,
    output logic             port3_power_oe_n,
    output logic [2:0]       port_overcurrent,
    output logic [2:0]       port_available,
    output logic             port3_non_removable,
    output logic             port3_shared_pins,
    output logic             irq
);

    function automatic logic power_on_for(input logic [3:0] code, input logic u2,
                                          input logic u3, input logic gp);
        case (code)
            pps_pkg::PWR_USB2:   power_on_for = u2;
            pps_pkg::PWR_USB3:   power_on_for = u3;
            pps_pkg::PWR_EITHER: power_on_for = u2 | u3;
            pps_pkg::PWR_GPIO:   power_on_for = gp;
            default:             power_on_for = 1'b0;
        endcase
    endfunction

    function automatic logic overcurrent_for(input logic [3:0] code, input logic pin,
                                             input logic gp);
        case (code)
            pps_pkg::OC_PIN:   overcurrent_for = pin;
            pps_pkg::OC_GPIO:  overcurrent_for = gp;
            pps_pkg::OC_FORCE: overcurrent_for = 1'b1;
            default:           overcurrent_for = 1'b0;
        endcase
    endfunction

    // Two-stage synchronisers for pin inputs
    logic [7:0]  pin_meta_reg;
    logic [7:0]  pin_sync_reg;
    logic        gpio_pwr_s;
    logic [2:0]  oc_pin_s;
    logic [2:0]  oc_gpio_s;
    logic        p3_pin_s;

    logic        loaded_reg;
    logic [7:0]  pwr3_reg;
    logic [3:0]  ovc_reg [3];
    logic [2:0]  chg_reg;
    logic [5:0]  irq_stat_reg;
    logic [5:0]  irq_en_reg;
    logic [2:0]  oc_prev_reg;

    logic        aw_held_reg;
    logic        w_held_reg;
    logic [17:0] aw_idx_reg;
    logic [7:0]  wdata_reg;
    logic        wlane_reg;
    logic        do_write;
    logic        wr_hit;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [2:0]  chg_set;
    logic [5:0]  irq_events;
    logic [5:0]  irq_clear;
    logic        p3_power;
    logic [2:0]  oc_src_pin;
    logic [2:0]  oc_next;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end
        else
        begin
            pin_meta_reg <= {port3_power_in, overcurrent_gpio_pin, overcurrent_sense_pin,
                             power_gpio_pin};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign gpio_pwr_s = pin_sync_reg[0];
    assign oc_pin_s   = pin_sync_reg[3:1];
    assign oc_gpio_s  = pin_sync_reg[6:4];
    assign p3_pin_s   = pin_sync_reg[7];

    // AXI write side: address and data taken in either order, answered one edge later
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            aw_idx_reg   <= 18'h00000;
            wdata_reg    <= 8'h00;
            wlane_reg    <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pps_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_idx_reg  <= s_axi_awaddr[19:2];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata[7:0];
                wlane_reg  <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? pps_pkg::RESP_OKAY : pps_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb
    begin
        case (aw_idx_reg)
            pps_pkg::IDX_PWR3, pps_pkg::IDX_OVC1, pps_pkg::IDX_OVC2, pps_pkg::IDX_OVC3,
            pps_pkg::IDX_CHG, pps_pkg::IDX_IRQ_ST, pps_pkg::IDX_IRQ_CL,
            pps_pkg::IDX_IRQ_EN: wr_hit = 1'b1;
            default:             wr_hit = 1'b0;
        endcase
    end

    // Configuration load at the first edge after reset, then software writes
    // configuration load
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            loaded_reg <= 1'b0;
            pwr3_reg   <= pps_pkg::PWR3_RST;
            ovc_reg[0] <= pps_pkg::OVC_RST;
            ovc_reg[1] <= pps_pkg::OVC_RST;
            ovc_reg[2] <= pps_pkg::OVC_RST;
            irq_en_reg <= pps_pkg::IRQ_RST;
        end
        else if (!loaded_reg)
        begin
            loaded_reg <= 1'b1;
            pwr3_reg   <= cfg_port3_power_select & ~(8'h01 << pps_pkg::RSVD_BIT);
            ovc_reg[0] <= cfg_port1_overcurrent_code;
            ovc_reg[1] <= cfg_port2_overcurrent_code;
            ovc_reg[2] <= cfg_port3_overcurrent_code;
        end
        else if (do_write && wlane_reg)
        begin
            case (aw_idx_reg)
                pps_pkg::IDX_PWR3:   pwr3_reg   <= wdata_reg & ~(8'h01 << pps_pkg::RSVD_BIT);
                pps_pkg::IDX_OVC1:   ovc_reg[0] <= wdata_reg[3:0];
                pps_pkg::IDX_OVC2:   ovc_reg[1] <= wdata_reg[3:0];
                pps_pkg::IDX_OVC3:   ovc_reg[2] <= wdata_reg[3:0];
                pps_pkg::IDX_IRQ_EN: irq_en_reg <= wdata_reg[5:0];
                default:             irq_en_reg <= irq_en_reg;
            endcase
        end
    end

    // handshake latched only before enumeration; a set beats a write
    assign chg_set = charging_host_port_detect & {3{!hub_enumerated}};

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            chg_reg <= pps_pkg::CHG_RST;
        end
        else if (do_write && wlane_reg && aw_idx_reg == pps_pkg::IDX_CHG)
        begin
            chg_reg <= wdata_reg[2:0] | chg_set;
        end
        else
        begin
            chg_reg <= chg_reg | chg_set;
        end
    end

    // Port 3 power source, disabled port never powered
    // disable overrides
    assign p3_power = !pwr3_reg[pps_pkg::DIS_BIT] &&
                      power_on_for(pwr3_reg[3:0], usb2_port_power_on, usb3_port_power_on,
                                   gpio_pwr_s);

    // shared pin sense
    // In shared mode the pin is released while powered and the switch pulls it low on fault
    assign oc_src_pin = {pwr3_reg[pps_pkg::SHARED_BIT] ? (p3_power && !p3_pin_s) : oc_pin_s[2],
                         oc_pin_s[1:0]};

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            oc_next[i] = overcurrent_for(ovc_reg[i], oc_src_pin[i], oc_gpio_s[i]);
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            port3_power_out     <= 1'b0;
            port3_power_oe_n    <= 1'b1;
            port_overcurrent    <= 3'h0;
            port_available      <= 3'h0;
            port3_non_removable <= 1'b0;
            port3_shared_pins   <= 1'b0;
            oc_prev_reg         <= 3'h0;
        end
        else
        begin
            port3_power_out     <= pwr3_reg[pps_pkg::SHARED_BIT] ? 1'b0 : p3_power;
            port3_power_oe_n    <= pwr3_reg[pps_pkg::SHARED_BIT] ? p3_power : 1'b0;
            port_overcurrent    <= oc_next;
            oc_prev_reg         <= port_overcurrent;
            port_available      <= {ovc_reg[2] != pps_pkg::OC_DISABLED &&
                                    !pwr3_reg[pps_pkg::DIS_BIT],
                                    ovc_reg[1] != pps_pkg::OC_DISABLED,
                                    ovc_reg[0] != pps_pkg::OC_DISABLED};
            port3_non_removable <= pwr3_reg[pps_pkg::NONREM_BIT];
            port3_shared_pins   <= pwr3_reg[pps_pkg::SHARED_BIT];
        end
    end

    // Sticky interrupt status; a new event wins over a clear in the same cycle
    assign irq_events = {port_overcurrent & ~oc_prev_reg, chg_set & ~chg_reg};
    assign irq_clear  = (do_write && wlane_reg && aw_idx_reg == pps_pkg::IDX_IRQ_CL) ?
                        wdata_reg[5:0] : 6'h00;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_stat_reg <= pps_pkg::IRQ_RST;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_events;
            irq <= |(((irq_stat_reg & ~irq_clear) | irq_events) & irq_en_reg);
        end
    end

    // Read side
    always_comb
    begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        case (s_axi_araddr[19:2])
            pps_pkg::IDX_PWR3:   rd_word[7:0] = pwr3_reg;
            pps_pkg::IDX_OVC1:   rd_word[3:0] = ovc_reg[0];
            pps_pkg::IDX_OVC2:   rd_word[3:0] = ovc_reg[1];
            pps_pkg::IDX_OVC3:   rd_word[3:0] = ovc_reg[2];
            pps_pkg::IDX_CHG:    rd_word[2:0] = chg_reg;
            pps_pkg::IDX_IRQ_ST: rd_word[5:0] = irq_stat_reg;
            pps_pkg::IDX_IRQ_EN: rd_word[5:0] = irq_en_reg;
            pps_pkg::IDX_IRQ_CL: rd_word = 32'h00000000;
            default:             rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= pps_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? pps_pkg::RESP_OKAY : pps_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: sim/pps_port_model.sv
// Model of the downstream power switch and over-current sensors.
// Assumes the bench sets the sensed conditions; sense pins are active high levels.
`timescale 1ns/1ns
`default_nettype none

module pps_port_model
(
    input  wire logic [2:0] sense_set,
    input  wire logic [2:0] gpio_set,
    input  wire logic       fault_set,
    input  wire logic       port3_power_out,
    input  wire logic       port3_power_oe_n,
    output logic [2:0]      overcurrent_sense_pin,
    output logic [2:0]      overcurrent_gpio_pin,
    output logic            port3_power_in
);
    assign overcurrent_sense_pin = sense_set;
    assign overcurrent_gpio_pin  = gpio_set;
    // Shared pin is pulled up unless the hub drives it or the switch pulls it low on a fault
    assign port3_power_in = !port3_power_oe_n ? port3_power_out : !fault_set;
endmodule

`default_nettype wire

// File: sim/pps_regs_properties.sv
// Checker for the port power select bank: bus handshakes and pin mode relations.
// Assumes it is bound to pps_regs and sees only the ports of that module.
`timescale 1ns/1ns
`default_nettype none

module pps_regs_chk
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        port3_power_out,
    input wire logic        port3_power_oe_n,
    input wire logic        port3_shared_pins
);
    logic [1:0] up_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Pin outputs only follow the mode once the configuration load has landed
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            up_reg <= 2'h0;
        else if (up_reg != 2'h3)
            up_reg <= up_reg + 2'h1;
    end

    chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    chk_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not retired");
    chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed while waiting");
    chk_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    chk_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during response");
    chk_rsvd_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_err_data: assert property (s_axi_rvalid && s_axi_rresp == pps_pkg::RESP_SLVERR |->
        s_axi_rdata == 32'h0) else $error("error read carries data");
    chk_shared_drive: assert property (up_reg == 2'h3 && port3_shared_pins &&
        $past(port3_shared_pins) |-> !port3_power_out) else $error("shared pin driven high");
    chk_split_drive: assert property (up_reg == 2'h3 && !port3_shared_pins &&
        !$past(port3_shared_pins) |-> !port3_power_oe_n) else $error("power pin not driven");
endmodule

bind pps_regs pps_regs_chk u_chk
(
    .clk(clk), .nrst(nrst), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port3_power_out(port3_power_out), .port3_power_oe_n(port3_power_oe_n),
    .port3_shared_pins(port3_shared_pins)
);

`default_nettype wire

// File: sim/tb_pps_regs.sv
// Bench for the port power select bank: bus access, power and sense codes, interrupts.
// Assumes pps_pkg, pps_regs, the port model and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none

module tb_pps_regs;
    logic        clk = 1'b0, nrst = 1'b0;
    logic [19:0] awaddr = 20'h0, araddr = 20'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        u2 = 1'b0, u3 = 1'b0, enum_done = 1'b0, gp = 1'b0, flt = 1'b0;
    logic [2:0]  chg = 3'h0, sns = 3'h0, ogp = 3'h0, oc, avail, sns_pin, gp_pin;
    // Selects and flags are written only before the hub enumerates
    logic [7:0]  cfg_pwr = 8'h51;
    logic        awrdy, wrdy, bvld, arrdy, rvld, p3_in, p3_out, p3_oe_n, nonrem, shared, irq;
    logic [1:0]  bresp, rresp;
    int          fail_count = 0, check_count = 0, cyc = 0;

    pps_regs u_dut
    (
        .clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvld), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arrdy),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvld), .s_axi_rready(rready),
        .cfg_port3_power_select(cfg_pwr), .cfg_port1_overcurrent_code(4'h1),
        .cfg_port2_overcurrent_code(4'h2), .cfg_port3_overcurrent_code(4'hf),
        .usb2_port_power_on(u2), .usb3_port_power_on(u3), .hub_enumerated(enum_done),
        .charging_host_port_detect(chg), .power_gpio_pin(gp), .overcurrent_sense_pin(sns_pin),
        .overcurrent_gpio_pin(gp_pin), .port3_power_in(p3_in), .port3_power_out(p3_out),
        .port3_power_oe_n(p3_oe_n), .port_overcurrent(oc), .port_available(avail),
        .port3_non_removable(nonrem), .port3_shared_pins(shared), .irq(irq)
    );

    pps_port_model u_far
    (
        .sense_set(sns), .gpio_set(ogp), .fault_set(flt), .port3_power_out(p3_out),
        .port3_power_oe_n(p3_oe_n), .overcurrent_sense_pin(sns_pin),
        .overcurrent_gpio_pin(gp_pin), .port3_power_in(p3_in)
    );

    task automatic conclude;
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [17:0] i, input logic [31:0] d, input logic [1:0] er);
        logic a, w, ta, tw;
        a = 1'b1;
        w = 1'b1;
        @(posedge clk);
        awaddr  <= {i, 2'b00};
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (a || w)
        begin
            @(negedge clk);
            ta = a && awrdy;
            tw = w && wrdy;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            a = a && !ta;
            w = w && !tw;
        end
        do @(negedge clk); while (bvld !== 1'b1);
        chk("bresp", 32'(er), 32'(bresp));
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [17:0] i, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr  <= {i, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(negedge clk); while (arrdy !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvld !== 1'b1);
        chk("rdata", e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
        @(posedge clk);
        rready <= 1'b0;
    endtask

    task automatic t_load;
        rd(pps_pkg::IDX_PWR3, 32'h11, pps_pkg::RESP_OKAY);
        rd(pps_pkg::IDX_OVC3, 32'h0f, pps_pkg::RESP_OKAY);
        chk("non removable", 32'h1, 32'(nonrem));
        chk("forced oc3", 32'h1, 32'(oc[2]));
        chk("available", 32'h7, 32'(avail));
    endtask

    task automatic t_power;
        logic e;
        for (int c = 0; c < 6; c++)
        begin
            wr(pps_pkg::IDX_PWR3, 32'(c), pps_pkg::RESP_OKAY);
            for (int v = 0; v < 8; v++)
            begin
                @(posedge clk);
                u2 <= v[0];
                u3 <= v[1];
                gp <= v[2];
                wt(5);
                e = c == 1 ? v[0] : c == 2 ? v[1] : c == 3 ? v[0] | v[1] : c == 4 ? v[2] : 1'b0;
                chk("power out", 32'(e), 32'(p3_out));
            end
        end
        wr(pps_pkg::IDX_PWR3, 32'h23, pps_pkg::RESP_OKAY);
        wt(3);
        chk("disabled power", 32'h0, 32'(p3_out));
        chk("disabled avail", 32'h0, 32'(avail[2]));
    endtask

    task automatic t_ovc;
        logic [3:0] cd [5] = '{4'h0, 4'h2, 4'hf, 4'h5, 4'h1};
        logic       e;
        for (int k = 0; k < 5; k++)
        begin
            wr(pps_pkg::IDX_OVC1, 32'(cd[k]), pps_pkg::RESP_OKAY);
            for (int v = 0; v < 4; v++)
            begin
                @(posedge clk);
                sns <= {2'b00, v[0]};
                ogp <= {1'b0, v[1], v[1]};
                wt(5);
                e = cd[k] == 4'h1 ? v[0] : cd[k] == 4'h2 ? v[1] : cd[k] == 4'hf;
                chk("oc1", 32'(e), 32'(oc[0]));
                chk("oc2", 32'(v[1]), 32'(oc[1]));
            end
            chk("avail1", 32'(cd[k] != 4'h0), 32'(avail[0]));
        end
    endtask

    task automatic t_shared;
        wr(pps_pkg::IDX_OVC3, 32'h1, pps_pkg::RESP_OKAY);
        wr(pps_pkg::IDX_PWR3, 32'h81, pps_pkg::RESP_OKAY);
        wt(5);
        chk("shared oe_n", 32'h1, 32'(p3_oe_n));
        chk("shared oc3", 32'h0, 32'(oc[2]));
        @(posedge clk);
        flt <= 1'b1;
        wt(5);
        chk("shared fault", 32'h1, 32'(oc[2]));
        chk("shared flag", 32'h1, 32'(shared));
        @(posedge clk);
        flt <= 1'b0;
        wr(pps_pkg::IDX_PWR3, 32'h01, pps_pkg::RESP_OKAY);
    endtask

    task automatic t_irq;
        wr(pps_pkg::IDX_IRQ_CL, 32'h3f, pps_pkg::RESP_OKAY);
        wr(pps_pkg::IDX_IRQ_EN, 32'h3f, pps_pkg::RESP_OKAY);
        wt(3);
        chk("irq idle", 32'h0, 32'(irq));
        @(posedge clk);
        chg <= 3'h2;
        @(posedge clk);
        chg <= 3'h0;
        wt(3);
        rd(pps_pkg::IDX_CHG, 32'h2, pps_pkg::RESP_OKAY);
        chk("irq set", 32'h1, 32'(irq));
        rd(pps_pkg::IDX_IRQ_ST, 32'h2, pps_pkg::RESP_OKAY);
        wr(pps_pkg::IDX_IRQ_EN, 32'h0, pps_pkg::RESP_OKAY);
        wt(3);
        chk("irq masked", 32'h0, 32'(irq));
        wr(pps_pkg::IDX_IRQ_CL, 32'h2, pps_pkg::RESP_OKAY);
        rd(pps_pkg::IDX_IRQ_ST, 32'h0, pps_pkg::RESP_OKAY);
        rd(pps_pkg::IDX_IRQ_CL, 32'h0, pps_pkg::RESP_OKAY);
        // Handshake lands on the edge that applies the clear, and must survive it
        fork
            wr(pps_pkg::IDX_IRQ_CL, 32'h3f, pps_pkg::RESP_OKAY);
            begin
                repeat (2) @(posedge clk);
                chg <= 3'h4;
                @(posedge clk);
                chg <= 3'h0;
            end
        join
        @(posedge clk);
        ogp <= 3'h0;
        wt(5);
        @(posedge clk);
        ogp <= 3'h2;
        wt(5);
        rd(pps_pkg::IDX_IRQ_ST, 32'h14, pps_pkg::RESP_OKAY);
        @(posedge clk);
        enum_done <= 1'b1;
        chg       <= 3'h1;
        @(posedge clk);
        chg <= 3'h0;
        wt(3);
        rd(pps_pkg::IDX_CHG, 32'h6, pps_pkg::RESP_OKAY);
        wr(pps_pkg::IDX_CHG, 32'h0, pps_pkg::RESP_OKAY);
        rd(pps_pkg::IDX_CHG, 32'h0, pps_pkg::RESP_OKAY);
        wr(18'h0, 32'h5a, pps_pkg::RESP_SLVERR);
        rd(18'h0, 32'h0, pps_pkg::RESP_SLVERR);
    endtask

    initial
    begin
        forever #5 clk = ~clk;
    end

    // A hung handshake ends the run as a failure
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            fail_count++;
            conclude();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        t_load();
        t_power();
        t_ovc();
        t_shared();
        t_irq();
        conclude();
    end
endmodule

`default_nettype wire
